// file: hdl/cfp_defs.vh
`ifndef CFP_DEFS_VH
`define CFP_DEFS_VH
// ****************************************************
// apb register byte addresses
// ****************************************************
`define CFP_REG_FLAGS 8'h00
`define CFP_REG_PCL 8'h04
`define CFP_REG_PCH 8'h08
`define CFP_REG_TABLE_POINTER_LOW 8'h0c
`define CFP_REG_TABLE_POINTER_HIGH 8'h10
`define CFP_REG_TABLE_READ_HIGH_BYTE 8'h14
`define CFP_REG_ACC 8'h18
`define CFP_REG_CMD 8'h1c
`define CFP_REG_STAT 8'h20
// ****************************************************
// flag register bit positions
// ****************************************************
`define CFP_SC 7
`define CFP_CZ 6
`define CFP_TO 5
`define CFP_PDF 4
`define CFP_OV 3
`define CFP_Z 2
`define CFP_AC 1
`define CFP_C 0
`define CFP_FLAGS_RW 8'hcf
// ****************************************************
// command word layout
// ****************************************************
`define CFP_CMD_OP 3:0
`define CFP_CMD_ADDR 12:4
`define CFP_CMD_DEST 13
`define CFP_CMD_LONG 14
`define CFP_CMD_W 15
// ****************************************************
// operations
// ****************************************************
`define CFP_OP_MOVA 4'h0
`define CFP_OP_MOVM 4'h1
`define CFP_OP_ADD 4'h2
`define CFP_OP_ADC 4'h3
`define CFP_OP_SUB 4'h4
`define CFP_OP_SBC 4'h5
`define CFP_OP_AND 4'h6
`define CFP_OP_OR 4'h7
`define CFP_OP_XOR 4'h8
`define CFP_OP_RLC 4'h9
`define CFP_OP_RRC 4'ha
`define CFP_OP_TABRD 4'hb
`define CFP_OP_CLRWDT 4'hc
`define CFP_OP_HALT 4'hd
// ****************************************************
// data space: sector bit, mapped special locations
// ****************************************************
`define CFP_SECTOR_BIT 8
`define CFP_MEM_FLAGS 9'h00a
`define CFP_MEM_PCL 9'h006
`define CFP_PC_W 13
`define CFP_PCH_W 5
`endif

// file: hdl/cfp_dmem.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// data memory, two sectors, registered read
// ****************************************************
module cfp_dmem (
   input wire pclk,
   input wire wr_en,
   input wire [8:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:511];

   always @(posedge pclk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // cfp_dmem
`default_nettype wire

// file: hdl/cfp_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defs.vh"
// ****************************************************
// alu: result and carry-type flags
// ****************************************************
module cfp_alu (
   input wire [3:0] op,
   input wire [7:0] a,
   input wire [7:0] b,
   input wire cin,
   output reg [7:0] res,
   output reg carry,
   output reg half_carry,
   output reg overflow
);
   reg [7:0] bx;
   reg ci;
   reg [8:0] sum9;
   reg [4:0] nib;
   reg [7:0] low7;

   always @* begin
      bx = b;
      ci = 1'b0;
      case (op)
         `CFP_OP_ADC: ci = cin;
         `CFP_OP_SUB: begin
            bx = ~b;
            ci = 1'b1;
         end
         `CFP_OP_SBC: begin
            bx = ~b;
            ci = cin;
         end
         default: ci = 1'b0;
      endcase
      sum9 = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
      nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
      low7 = {1'b0, a[6:0]} + {1'b0, bx[6:0]} + {7'h00, ci};
      res = sum9[7:0];
      carry = sum9[8];
      half_carry = nib[4];
      overflow = sum9[8] ^ low7[7];
      case (op)
         `CFP_OP_AND: res = a & b;
         `CFP_OP_OR: res = a | b;
         `CFP_OP_XOR: res = a ^ b;
         `CFP_OP_RLC: begin
            res = {b[6:0], cin};
            carry = b[7];
         end
         `CFP_OP_RRC: begin
            res = {cin, b[7:1]};
            carry = b[0];
         end
         default: res = sum9[7:0];
      endcase
   end
endmodule // cfp_alu
`default_nettype wire

// file: hdl/cfp_core.v
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defs.vh"
// Overview of operation
// - eight-bit flag register, SC CZ TO SLEEP_ENTERED_FLAG OV Z AC C from bit 7 down.
// - zero flag set when an arithmetic or logic result is zero.
// - carry is add carry-out or no subtract borrow; rotates update it.
// - half carry is low-nibble carry, or no nibble borrow on subtract.
// - overflow is carry into bit 7 differing from carry out of it.
// - signed-compare flag is new overflow xor result msb.
// - plain subtracts copy zero result into chained-zero flag.
// - subtract-with-borrow ands old chained-zero with new zero result.
// - all other operations leave chained-zero flag untouched.
// - software writes never change watchdog-expired or sleep-entered flags.
// - watchdog flag cleared by reset, clear or halt; set by timeout.
// - sleep flag cleared by reset or watchdog clear; set by halt.
// - flags are never saved automatically on call or interrupt.
// - program counter low-byte write replaces only the low eight bits.
// - a low-byte jump inserts one dummy cycle.
// - table read fetches at pointer pair, high byte to table high.
// - extended address: bit 8 is sector, low eight bits offset.
// - no memory-to-memory move; data passes through the accumulator.
module cfp_core (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire watchdog_timeout,
   output wire [`CFP_PC_W-1:0] pc,
   output reg dummy_cycle,
   output reg [15:0] prog_addr,
   output reg prog_rd,
   input wire [15:0] prog_data,
   output reg halt_pulse,
   output reg watchdog_clear_instruction,
   output wire [7:0] cpu_flag_register
);
   localparam ST_IDLE = 3'd0;
   localparam ST_READ = 3'd1;
   localparam ST_EXEC = 3'd2;
   localparam ST_DUMMY = 3'd3;

   // ****************************************************
   // decode helpers
   // ****************************************************
   function is_arith;
      input [3:0] op;
      begin
         is_arith = (op == `CFP_OP_ADD) || (op == `CFP_OP_ADC) ||
            (op == `CFP_OP_SUB) || (op == `CFP_OP_SBC);
      end
   endfunction

   function is_logic;
      input [3:0] op;
      begin
         is_logic = (op == `CFP_OP_AND) || (op == `CFP_OP_OR) ||
            (op == `CFP_OP_XOR);
      end
   endfunction

   function is_rotate;
      input [3:0] op;
      begin
         is_rotate = (op == `CFP_OP_RLC) || (op == `CFP_OP_RRC);
      end
   endfunction

   reg [2:0] state;
   reg was_idle;
   reg [7:0] arith_flags;
   reg sys_to;
   reg sys_pdf;
   wire [7:0] flags;
   reg [7:0] program_counter_low_byte;
   reg [`CFP_PCH_W-1:0] pc_high;
   reg [7:0] table_pointer_low;
   reg [7:0] table_pointer_high;
   reg [7:0] table_read_high_byte;
   reg [7:0] acc;
   reg [`CFP_CMD_W-1:0] cmd;
   reg wdt_meta;
   reg wdt_sync;
   reg [7:0] operand;
   reg [7:0] dest_data;
   reg to_acc;
   reg mem_we;
   reg flag_dest;
   reg pcl_dest;
   reg [7:0] next_flags;
   reg [31:0] next_prdata;
   reg addr_ok;

   wire [3:0] op;
   wire [8:0] ext_addr;
   wire [7:0] dmem_rdata;
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_ac;
   wire alu_ov;
   wire alu_z;
   wire apb_acc;
   wire apb_wr;
   wire in_exec;
   wire do_halt;
   wire do_clrwdt;

   assign op = cmd[`CFP_CMD_OP];
   // short forms reach sector 0 only
   assign ext_addr = cmd[`CFP_CMD_LONG] ? cmd[`CFP_CMD_ADDR] :
      {1'b0, cmd[`CFP_SECTOR_BIT+3:4]};
   assign pc = {pc_high, program_counter_low_byte};
   assign flags = {arith_flags[7:6], sys_to, sys_pdf, arith_flags[3:0]};
   assign cpu_flag_register = flags;
   assign pready = (state == ST_IDLE) && was_idle;
   assign apb_acc = psel && penable && pready;
   assign apb_wr = apb_acc && pwrite;
   assign pslverr = apb_acc && !addr_ok;
   assign in_exec = (state == ST_EXEC);
   assign do_halt = in_exec && (op == `CFP_OP_HALT);
   assign do_clrwdt = in_exec && (op == `CFP_OP_CLRWDT);
   assign alu_z = (alu_res == 8'h00);

   // ****************************************************
   // datapath
   // ****************************************************
   cfp_alu u_alu (
      .op(op),
      .a(acc),
      .b(operand),
      .cin(flags[`CFP_C]),
      .res(alu_res),
      .carry(alu_c),
      .half_carry(alu_ac),
      .overflow(alu_ov)
   );

   cfp_dmem u_dmem (
      .pclk(pclk),
      .wr_en(mem_we),
      .addr(ext_addr),
      .wdata(dest_data),
      .rdata(dmem_rdata)
   );

   // ****************************************************
   // operand select and destination steering
   // ****************************************************
   always @* begin
      if (ext_addr == `CFP_MEM_FLAGS) begin
         operand = flags;
      end else if (ext_addr == `CFP_MEM_PCL) begin
         operand = program_counter_low_byte;
      end else begin
         operand = dmem_rdata;
      end
      // results land in acc or one memory byte, never memory to memory
      case (op)
         `CFP_OP_MOVA: begin
            dest_data = operand;
            to_acc = 1'b1;
         end
         `CFP_OP_MOVM: begin
            dest_data = acc;
            to_acc = 1'b0;
         end
         `CFP_OP_TABRD: begin
            dest_data = prog_data[7:0];
            to_acc = !cmd[`CFP_CMD_DEST];
         end
         `CFP_OP_CLRWDT, `CFP_OP_HALT: begin
            dest_data = acc;
            to_acc = 1'b1;
         end
         default: begin
            dest_data = alu_res;
            to_acc = !cmd[`CFP_CMD_DEST];
         end
      endcase
      flag_dest = in_exec && !to_acc && (ext_addr == `CFP_MEM_FLAGS);
      pcl_dest = in_exec && !to_acc && (ext_addr == `CFP_MEM_PCL);
      mem_we = in_exec && !to_acc && !flag_dest && !pcl_dest;
   end

   // ****************************************************
   // next flag value for writable bits
   // ****************************************************
   always @* begin
      next_flags = flags;
      if (apb_wr && (paddr == `CFP_REG_FLAGS)) begin
         next_flags = pwdata[7:0];
      end else if (flag_dest) begin
         next_flags = dest_data;
      end else if (in_exec && is_arith(op)) begin
         next_flags[`CFP_Z] = alu_z;
         next_flags[`CFP_C] = alu_c;
         next_flags[`CFP_AC] = alu_ac;
         next_flags[`CFP_OV] = alu_ov;
         next_flags[`CFP_SC] = alu_ov ^ alu_res[7];
         if (op == `CFP_OP_SUB) begin
            next_flags[`CFP_CZ] = alu_z;
         end else if (op == `CFP_OP_SBC) begin
            next_flags[`CFP_CZ] = flags[`CFP_CZ] & alu_z;
         end
      end else if (in_exec && is_logic(op)) begin
         next_flags[`CFP_Z] = alu_z;
      end else if (in_exec && is_rotate(op)) begin
         next_flags[`CFP_C] = alu_c;
      end
      // chained zero otherwise held
   end

   // ****************************************************
   // flag register
   // ****************************************************
   // arithmetic bits have no reset value
   always @(posedge pclk) begin
      arith_flags[7:6] <= next_flags[7:6];
      arith_flags[3:0] <= next_flags[3:0];
   end

   // timeout set wins over a same-cycle clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_to <= 1'b0;
         sys_pdf <= 1'b0;
      end else begin
         if (wdt_sync) begin
            sys_to <= 1'b1;
         end else if (do_clrwdt || do_halt) begin
            sys_to <= 1'b0;
         end
         if (do_halt) begin
            sys_pdf <= 1'b1;
         end else if (do_clrwdt) begin
            sys_pdf <= 1'b0;
         end
      end
   end

   // ****************************************************
   // sequencer and software-visible registers
   // ****************************************************
   // nothing here saves flags on call or interrupt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         was_idle <= 1'b1;
         wdt_meta <= 1'b0;
         wdt_sync <= 1'b0;
         program_counter_low_byte <= 8'h00;
         pc_high <= {`CFP_PCH_W{1'b0}};
         table_pointer_low <= 8'h00;
         table_pointer_high <= 8'h00;
         table_read_high_byte <= 8'h00;
         acc <= 8'h00;
         cmd <= {`CFP_CMD_W{1'b0}};
         dummy_cycle <= 1'b0;
         prog_addr <= 16'h0000;
         prog_rd <= 1'b0;
         halt_pulse <= 1'b0;
         watchdog_clear_instruction <= 1'b0;
      end else begin
         wdt_meta <= watchdog_timeout;
         wdt_sync <= wdt_meta;
         was_idle <= (state == ST_IDLE);
         prog_rd <= 1'b0;
         dummy_cycle <= 1'b0;
         halt_pulse <= do_halt;
         watchdog_clear_instruction <= do_clrwdt;
         case (state)
            ST_IDLE: begin
               if (apb_wr) begin
                  case (paddr)
                     `CFP_REG_PCL: begin
                        program_counter_low_byte <= pwdata[7:0];
                        state <= ST_DUMMY;
                     end
                     `CFP_REG_PCH: pc_high <= pwdata[`CFP_PCH_W-1:0];
                     `CFP_REG_TABLE_POINTER_LOW: table_pointer_low <= pwdata[7:0];
                     `CFP_REG_TABLE_POINTER_HIGH: table_pointer_high <= pwdata[7:0];
                     `CFP_REG_ACC: acc <= pwdata[7:0];
                     `CFP_REG_CMD: begin
                        cmd <= pwdata[`CFP_CMD_W-1:0];
                        state <= ST_READ;
                        // fetch early so the word is ready in exec
                        if (pwdata[`CFP_CMD_OP] == `CFP_OP_TABRD) begin
                           prog_addr <= {table_pointer_high,
                              table_pointer_low};
                           prog_rd <= 1'b1;
                        end
                     end
                     default: state <= ST_IDLE;
                  endcase
               end
            end
            ST_READ: begin
               state <= ST_EXEC;
            end
            ST_EXEC: begin
               if (op == `CFP_OP_TABRD) begin
                  table_read_high_byte <= prog_data[15:8];
               end
               if (to_acc) begin
                  acc <= dest_data;
               end
               if (pcl_dest) begin
                  program_counter_low_byte <= dest_data;
                  state <= ST_DUMMY;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_DUMMY: begin
               dummy_cycle <= 1'b1;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************************
   // read mux and address check
   // ****************************************************
   always @* begin
      next_prdata = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         `CFP_REG_FLAGS: next_prdata[7:0] = flags;
         `CFP_REG_PCL: next_prdata[7:0] = program_counter_low_byte;
         `CFP_REG_PCH: next_prdata[`CFP_PCH_W-1:0] = pc_high;
         `CFP_REG_TABLE_POINTER_LOW: next_prdata[7:0] = table_pointer_low;
         `CFP_REG_TABLE_POINTER_HIGH: next_prdata[7:0] = table_pointer_high;
         `CFP_REG_TABLE_READ_HIGH_BYTE: next_prdata[7:0] = table_read_high_byte;
         `CFP_REG_ACC: next_prdata[7:0] = acc;
         `CFP_REG_CMD: next_prdata[`CFP_CMD_W-1:0] = cmd;
         `CFP_REG_STAT: next_prdata[0] = (state != ST_IDLE);
         default: addr_ok = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !pwrite) begin
         prdata <= next_prdata;
      end
   end
endmodule // cfp_core
`default_nettype wire

// file: verif/cfp_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defs.vh"
// ****************************************************
// port checker
// ****************************************************
module cfp_core_asserts (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire watchdog_timeout,
   input wire [`CFP_PC_W-1:0] pc,
   input wire dummy_cycle,
   input wire [15:0] prog_addr,
   input wire prog_rd,
   input wire [15:0] prog_data,
   input wire halt_pulse,
   input wire watchdog_clear_instruction,
   input wire [7:0] cpu_flag_register
);
   wire tk = psel & penable & pready;
   wire wr_pcl = tk & pwrite & (paddr == `CFP_REG_PCL);
   wire wr_flg = tk & pwrite & (paddr == `CFP_REG_FLAGS);
   wire rd_flg = tk & !pwrite & (paddr == `CFP_REG_FLAGS);
   wire [4:0] pc_hi = pc[12:8];
   wire [7:0] wlow = pwdata[7:0];
   wire to = cpu_flag_register[`CFP_TO];
   wire sleep_entered_flag = cpu_flag_register[`CFP_PDF];
   wire sys = halt_pulse | watchdog_clear_instruction;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pcl_jump:
      assert property (wr_pcl |=> pc == {$past(pc_hi), $past(wlow)})
      else $error("pc wrong after low byte write");
   a_jump_dummy:
      assert property (wr_pcl |-> ##[1:4] dummy_cycle)
      else $error("no dummy cycle after jump");
   a_dummy_one:
      assert property (dummy_cycle |=> !dummy_cycle)
      else $error("dummy cycle too long");
   a_flag_wr:
      assert property (wr_flg |=> (cpu_flag_register & `CFP_FLAGS_RW)
         == ($past(wlow) & `CFP_FLAGS_RW))
      else $error("writable flags not loaded");
   a_flag_ro:
      assert property (wr_flg |=> $stable(sleep_entered_flag))
      else $error("sleep flag changed by write");
   a_halt_pdf:
      assert property (halt_pulse |-> sleep_entered_flag)
      else $error("sleep flag not set by halt");
   a_clr_pdf:
      assert property (watchdog_clear_instruction |-> !sleep_entered_flag)
      else $error("sleep flag not cleared");
   a_pdf_cause:
      assert property ($changed(sleep_entered_flag) |-> sys)
      else $error("sleep flag changed without cause");
   a_to_fall:
      assert property ($fell(to) |-> sys)
      else $error("watchdog flag cleared without cause");
   a_to_set:
      assert property (watchdog_timeout [*4] |=> to)
      else $error("watchdog flag not set");
   a_flag_read:
      assert property (rd_flg && $stable(cpu_flag_register)
         |-> prdata == {24'h0, cpu_flag_register})
      else $error("flag read data wrong");
endmodule // cfp_core_asserts
bind cfp_core cfp_core_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .watchdog_timeout(watchdog_timeout), .pc(pc),
   .dummy_cycle(dummy_cycle), .prog_addr(prog_addr), .prog_rd(prog_rd),
   .prog_data(prog_data), .halt_pulse(halt_pulse),
   .watchdog_clear_instruction(watchdog_clear_instruction),
   .cpu_flag_register(cpu_flag_register));
`default_nettype wire

// file: verif/cpu_flags_and_pc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defs.vh"
// ****************************************************
// bench
// ****************************************************
module cpu_flags_and_pc_control_bench;
   typedef struct packed {
      logic [3:0] op;
      logic [7:0] a, b, fin, res, fout;
   } cfp_row_t;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic wdt = 1'h0;
   logic [15:0] prog_data = 16'h0;
   logic [31:0] rd;
   logic err;
   wire [31:0] prdata;
   wire pready, pslverr, dummy, prog_rd, halt_pulse, wdc;
   wire [`CFP_PC_W-1:0] pc;
   wire [15:0] prog_addr;
   wire [7:0] flags;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n_dummy = 0;
   // op, acc, memory operand, flags before, acc after, flags after
   cfp_row_t rows [14] = '{
      '{`CFP_OP_ADD, 8'h7f, 8'h01, 8'h40, 8'h80, 8'h4a},
      '{`CFP_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 8'h07},
      '{`CFP_OP_ADC, 8'h10, 8'h20, 8'h01, 8'h31, 8'h00},
      '{`CFP_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h00, 8'h47},
      '{`CFP_OP_SUB, 8'h80, 8'h01, 8'h40, 8'h7f, 8'h89},
      '{`CFP_OP_SBC, 8'h03, 8'h03, 8'h41, 8'h00, 8'h47},
      '{`CFP_OP_SBC, 8'h03, 8'h03, 8'h40, 8'hff, 8'h80},
      '{`CFP_OP_SBC, 8'h03, 8'h03, 8'h01, 8'h00, 8'h07},
      '{`CFP_OP_AND, 8'hf0, 8'h0f, 8'hcb, 8'h00, 8'hcf},
      '{`CFP_OP_OR, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00},
      '{`CFP_OP_XOR, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'h04},
      '{`CFP_OP_RLC, 8'h00, 8'h81, 8'h00, 8'h02, 8'h01},
      '{`CFP_OP_RRC, 8'h00, 8'h02, 8'h01, 8'h81, 8'h00},
      '{`CFP_OP_MOVA, 8'h00, 8'h33, 8'h00, 8'h33, 8'h00}};
   cfp_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .watchdog_timeout(wdt), .pc(pc), .dummy_cycle(dummy),
      .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
      .halt_pulse(halt_pulse), .watchdog_clear_instruction(wdc),
      .cpu_flag_register(flags));
   always #50 pclk = ~pclk;
   // program memory: word valid the cycle after the strobe
   always @(posedge pclk) begin
      if (dummy === 1'h1) n_dummy <= n_dummy + 1;
      prog_data <= (prog_rd === 1'h1) ? prog_addr ^ 16'ha5c3 : ~prog_data;
   end
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc >= 20000) begin
         n_errors = n_errors + 1;
         $display("timeout");
         close_out;
      end
   end
   task close_out;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one transfer, entered just after a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d});
   endtask
   task rc(input logic [7:0] a, input string nm, input logic [15:0] e);
      apb(1'h0, a, 32'h0);
      chk(nm, e, rd[15:0]);
   endtask
   task op(input logic [3:0] o, input logic [8:0] ad, input logic lng);
      apb(1'h1, `CFP_REG_CMD, {17'h0, lng, 1'h0, ad, o});
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk("reset flags", 16'h0, {14'h0, flags[5:4]});
      wr(`CFP_REG_FLAGS, 8'hff);
      rc(`CFP_REG_FLAGS, "flags ro", 16'hcf);
      chk("slverr mapped", 16'h0, {15'h0, err});
      rc(8'h24, "unmapped data", 16'h0);
      chk("slverr unmapped", 16'h1, {15'h0, err});
      $display("test flag write done");
      foreach (rows[i]) begin
         wr(`CFP_REG_ACC, rows[i].b);
         op(`CFP_OP_MOVM, 9'h020, 1'h0);
         wr(`CFP_REG_ACC, rows[i].a);
         wr(`CFP_REG_FLAGS, rows[i].fin);
         op(rows[i].op, 9'h020, 1'h0);
         rc(`CFP_REG_ACC, "acc", {8'h0, rows[i].res});
         rc(`CFP_REG_FLAGS, "flags", {8'h0, rows[i].fout});
      end
      $display("test alu rows done");
      wr(`CFP_REG_ACC, 8'h11);
      op(`CFP_OP_MOVM, 9'h020, 1'h0);
      wr(`CFP_REG_ACC, 8'h22);
      op(`CFP_OP_MOVM, 9'h120, 1'h1);
      op(`CFP_OP_MOVA, 9'h120, 1'h1);
      rc(`CFP_REG_ACC, "sector 1", 16'h22);
      op(`CFP_OP_MOVA, 9'h120, 1'h0);
      rc(`CFP_REG_ACC, "short form", 16'h11);
      $display("test sectors done");
      wr(`CFP_REG_PCH, 8'h15);
      wr(`CFP_REG_PCL, 8'h3c);
      chk("pc", 16'h153c, {3'h0, pc});
      repeat (2) @(posedge pclk);
      chk("dummy count", 16'h1, n_dummy[15:0]);
      wr(`CFP_REG_PCL, 8'h01);
      chk("pc", 16'h1501, {3'h0, pc});
      $display("test jump done");
      wr(`CFP_REG_TABLE_POINTER_LOW, 8'h34);
      wr(`CFP_REG_TABLE_POINTER_HIGH, 8'h12);
      op(`CFP_OP_TABRD, 9'h000, 1'h0);
      chk("prog addr", 16'h1234, prog_addr);
      rc(`CFP_REG_TABLE_READ_HIGH_BYTE, "table high", 16'hb7);
      rc(`CFP_REG_ACC, "table low", 16'hf7);
      $display("test table done");
      op(`CFP_OP_HALT, 9'h000, 1'h0);
      rc(`CFP_REG_FLAGS, "halt", 16'h10);
      wdt <= 1'h1;
      repeat (6) @(posedge pclk);
      wdt <= 1'h0;
      wr(`CFP_REG_FLAGS, 8'h00);
      rc(`CFP_REG_FLAGS, "timeout", 16'h30);
      op(`CFP_OP_HALT, 9'h000, 1'h0);
      rc(`CFP_REG_FLAGS, "halt clears", 16'h10);
      op(`CFP_OP_CLRWDT, 9'h000, 1'h0);
      rc(`CFP_REG_FLAGS, "clear", 16'h00);
      wdt <= 1'h1;
      repeat (6) @(posedge pclk);
      wdt <= 1'h0;
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk("reset again", 16'h0, {14'h0, flags[5:4]});
      $display("test system flags done");
      close_out;
   end
endmodule // cpu_flags_and_pc_control_bench
`default_nettype wire
